/* File: swsaa_defs.svh */
// constants for the single-wire slave access arbiter
`ifndef SWSAA_DEFS_SVH
`define SWSAA_DEFS_SVH

`define SWSAA_CLK_MHZ 25

`define SWSAA_T_RST_STD_US 120
`define SWSAA_T_RST_OVD_US 16
`define SWSAA_T_RST_LONG_US 690
`define SWSAA_T_SAMPLE_MS 666
`define SWSAA_T_SAMP_STD_US 30
`define SWSAA_T_SAMP_OVD_US 3
`define SWSAA_T_PWAIT_STD_US 30
`define SWSAA_T_PWAIT_OVD_US 3
`define SWSAA_T_PLOW_STD_US 120
`define SWSAA_T_PLOW_OVD_US 12

`define SWSAA_CYC_RST_STD (`SWSAA_T_RST_STD_US * `SWSAA_CLK_MHZ)
`define SWSAA_CYC_RST_OVD (`SWSAA_T_RST_OVD_US * `SWSAA_CLK_MHZ)
`define SWSAA_CYC_RST_LONG (`SWSAA_T_RST_LONG_US * `SWSAA_CLK_MHZ)
`define SWSAA_CYC_SAMPLE (`SWSAA_T_SAMPLE_MS * 1000 * `SWSAA_CLK_MHZ)
`define SWSAA_CYC_SAMP_STD (`SWSAA_T_SAMP_STD_US * `SWSAA_CLK_MHZ)
`define SWSAA_CYC_SAMP_OVD (`SWSAA_T_SAMP_OVD_US * `SWSAA_CLK_MHZ)
`define SWSAA_CYC_PWAIT_STD (`SWSAA_T_PWAIT_STD_US * `SWSAA_CLK_MHZ)
`define SWSAA_CYC_PWAIT_OVD (`SWSAA_T_PWAIT_OVD_US * `SWSAA_CLK_MHZ)
`define SWSAA_CYC_PLOW_STD (`SWSAA_T_PLOW_STD_US * `SWSAA_CLK_MHZ)
`define SWSAA_CYC_PLOW_OVD (`SWSAA_T_PLOW_OVD_US * `SWSAA_CLK_MHZ)

`define SWSAA_ROM_SKIP 8'hcc
`define SWSAA_ROM_OVD_SKIP 8'h3c
`define SWSAA_FN_CLEAR 8'h96
`define SWSAA_FN_FORCED 8'h55
`define SWSAA_FN_START 8'hcc

`define SWSAA_REG_CTRL 8'h00
`define SWSAA_REG_STATUS 8'h04
`define SWSAA_REG_TXDATA 8'h08
`define SWSAA_REG_RXDATA 8'h0c

`define SWSAA_CTRL_MISSION 0
`define SWSAA_CTRL_ALARM 1
`define SWSAA_CTRL_TXMODE 2
`define SWSAA_CTRL_SAMPLE 3
`define SWSAA_STAT_OVD 0
`define SWSAA_STAT_BUSY 1
`define SWSAA_STAT_COLL 2
`define SWSAA_STAT_PHASE 4
`define SWSAA_STAT_ROM 8
`define SWSAA_STAT_FUNC 16
`define SWSAA_RX_FULL 8

`define SWSAA_RESP_OKAY 2'b00
`define SWSAA_RESP_SLVERR 2'b10
`define SWSAA_TXDATA_RESET 8'hff

`endif

/* File: swsaa_pkg.sv */
// types shared by the single-wire slave access arbiter
package swsaa_pkg;

  typedef enum logic [2:0] {
    st_wait, st_rst, st_pwait, st_plow, st_rom, st_func, st_data
  } swsaa_state_t;

  typedef enum logic [2:0] {
    sel_ctrl, sel_status, sel_txdata, sel_rxdata, sel_none
  } swsaa_sel_t;

  typedef struct packed {
    swsaa_state_t st;
    logic ovd;
    logic coll;
    logic spoil;
    logic [23:0] busy_cnt;
    logic [11:0] slot_cnt;
    logic in_slot;
    logic tx_slot;
    logic dq_oe_n;
    logic [7:0] shreg;
    logic [2:0] bitn;
    logic [7:0] rom_cmd;
    logic [7:0] func_cmd;
    logic [7:0] rx_byte;
    logic rx_valid;
  } swsaa_core_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [15:0] low_cnt;
    logic fall;
    logic rise;
    logic rst_det;
    logic long_det;
  } swsaa_rx_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic mission;
    logic alarm_wait;
    logic tx_mode;
    logic [7:0] txdata;
    logic sample_start;
    logic coll_clr;
    logic [7:0] rx_byte;
    logic rx_full;
  } swsaa_regs_t;

endpackage

/* File: swsaa_core_if.sv */
// register side to line side signals
`timescale 1ns/1ps
`default_nettype none
interface swsaa_core_if;
  logic mission;
  logic alarm_wait;
  logic tx_mode;
  logic sample_start;
  logic coll_clr;
  logic [7:0] txdata;
  logic ovd;
  logic busy;
  logic coll;
  logic [2:0] phase;
  logic [7:0] rom_cmd;
  logic [7:0] func_cmd;
  logic [7:0] rx_byte;
  logic rx_valid;

  modport regs (
    output mission, alarm_wait, tx_mode, sample_start, coll_clr, txdata,
    input ovd, busy, coll, phase, rom_cmd, func_cmd, rx_byte, rx_valid
  );
  modport core (
    input mission, alarm_wait, tx_mode, sample_start, coll_clr, txdata,
    output ovd, busy, coll, phase, rom_cmd, func_cmd, rx_byte, rx_valid
  );
endinterface
`default_nettype wire

/* File: swsaa_line_rx.sv */
// line synchroniser, edge events and low-time reset detection
`timescale 1ns/1ps
`default_nettype none
`include "swsaa_defs.svh"
module swsaa_line_rx #(
  parameter int unsigned LONG_RST_CYC = `SWSAA_CYC_RST_LONG
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic dq_i,
  input wire logic ovd,
  input wire logic self_drive,
  output logic level,
  output logic fall,
  output logic rise,
  output logic rst_det,
  output logic long_det
);
  import swsaa_pkg::*;

  swsaa_rx_t r;
  swsaa_rx_t next_r;
  logic [15:0] thr;

  always_comb begin
    next_r = r;
    next_r.s1 = dq_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.fall = r.s3 && !r.s2;
    next_r.rise = !r.s3 && r.s2;
    thr = ovd ? 16'(`SWSAA_CYC_RST_OVD) : 16'(`SWSAA_CYC_RST_STD);
    // own presence pulse must not look like a reset
    if (r.s2 || self_drive) begin
      next_r.low_cnt = 16'h0;
    end else if (r.low_cnt != 16'hffff) begin
      next_r.low_cnt = r.low_cnt + 16'h1;
    end
    next_r.rst_det = (r.low_cnt == thr);
    next_r.long_det = (r.low_cnt == 16'(LONG_RST_CYC));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign level = r.s2;
  assign fall = r.fall;
  assign rise = r.rise;
  assign rst_det = r.rst_det;
  assign long_det = r.long_det;
endmodule
`default_nettype wire

/* File: swsaa_axil_regs.sv */
// axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "swsaa_defs.svh"
module swsaa_axil_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  swsaa_core_if.regs cif
);
  import swsaa_pkg::*;

  swsaa_regs_t r;
  swsaa_regs_t next_r;
  swsaa_sel_t wsel;
  swsaa_sel_t rsel;

  function automatic swsaa_sel_t reg_sel(input logic [7:0] addr);
    if (addr == `SWSAA_REG_CTRL) begin
      return sel_ctrl;
    end else if (addr == `SWSAA_REG_STATUS) begin
      return sel_status;
    end else if (addr == `SWSAA_REG_TXDATA) begin
      return sel_txdata;
    end else if (addr == `SWSAA_REG_RXDATA) begin
      return sel_rxdata;
    end else begin
      return sel_none;
    end
  endfunction

  always_comb begin
    next_r = r;
    next_r.sample_start = 1'b0;
    next_r.coll_clr = 1'b0;
    wsel = reg_sel(r.awaddr);
    rsel = reg_sel(s_axi_araddr);
    if (s_axi_awvalid && r.awready) begin
      next_r.aw_held = 1'b1;
      next_r.awready = 1'b0;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_held = 1'b1;
      next_r.wready = 1'b0;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = (wsel == sel_none) ? `SWSAA_RESP_SLVERR : `SWSAA_RESP_OKAY;
      if (r.wstrb[0]) begin
        if (wsel == sel_ctrl) begin
          next_r.mission = r.wdata[`SWSAA_CTRL_MISSION];
          next_r.alarm_wait = r.wdata[`SWSAA_CTRL_ALARM];
          next_r.tx_mode = r.wdata[`SWSAA_CTRL_TXMODE];
          next_r.sample_start = r.wdata[`SWSAA_CTRL_SAMPLE];
        end else if (wsel == sel_status) begin
          next_r.coll_clr = r.wdata[`SWSAA_STAT_COLL];
        end else if (wsel == sel_txdata) begin
          next_r.txdata = r.wdata[7:0];
        end
      end
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
    end
    if (s_axi_arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp = (rsel == sel_none) ? `SWSAA_RESP_SLVERR : `SWSAA_RESP_OKAY;
      next_r.rdata = 32'h0;
      if (rsel == sel_ctrl) begin
        next_r.rdata[`SWSAA_CTRL_MISSION] = r.mission;
        next_r.rdata[`SWSAA_CTRL_ALARM] = r.alarm_wait;
        next_r.rdata[`SWSAA_CTRL_TXMODE] = r.tx_mode;
      end else if (rsel == sel_status) begin
        next_r.rdata[`SWSAA_STAT_OVD] = cif.ovd;
        next_r.rdata[`SWSAA_STAT_BUSY] = cif.busy;
        next_r.rdata[`SWSAA_STAT_COLL] = cif.coll;
        next_r.rdata[`SWSAA_STAT_PHASE +: 3] = cif.phase;
        next_r.rdata[`SWSAA_STAT_ROM +: 8] = cif.rom_cmd;
        next_r.rdata[`SWSAA_STAT_FUNC +: 8] = cif.func_cmd;
      end else if (rsel == sel_txdata) begin
        next_r.rdata[7:0] = r.txdata;
      end else if (rsel == sel_rxdata) begin
        next_r.rdata[7:0] = r.rx_byte;
        next_r.rdata[`SWSAA_RX_FULL] = r.rx_full;
        next_r.rx_full = 1'b0;
      end
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end
    // a byte landing with the read keeps the full flag
    if (cif.rx_valid) begin
      next_r.rx_full = 1'b1;
      next_r.rx_byte = cif.rx_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
             txdata: `SWSAA_TXDATA_RESET, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign cif.mission = r.mission;
  assign cif.alarm_wait = r.alarm_wait;
  assign cif.tx_mode = r.tx_mode;
  assign cif.txdata = r.txdata;
  assign cif.sample_start = r.sample_start;
  assign cif.coll_clr = r.coll_clr;
endmodule
`default_nettype wire

/* File: swsaa_top.sv */
// single-wire slave front end with sampling arbitration
// Function
// - sampling has priority over bus commands
// - reset and ROM commands survive sampling
// - refuse start, forced, clear during mission
// - one sampling event blocks up to 666ms
// - colliding scratchpad write returns CRC all ones
// - colliding scratchpad read returns all-ones bytes
// - colliding copy looks rejected or unfinished
// - colliding memory read returns all-ones bytes
// - colliding stop-mission shows status all ones
// - one master; device only ever slave
// - slots start at master falling edge
// - line driven open drain only
// - long low time is a reset
// - reset, ROM, function, data in order
// - reset pulse answered with presence pulse
// - ROM commands are eight bits
// - reset of 690us clears overdrive flag
`timescale 1ns/1ps
`default_nettype none
`include "swsaa_defs.svh"
module swsaa_top #(
  parameter int unsigned LONG_RST_CYC = `SWSAA_CYC_RST_LONG,
  parameter int unsigned SAMPLE_CYC = `SWSAA_CYC_SAMPLE
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic dq_i,
  output logic dq_o,
  output logic dq_oe_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import swsaa_pkg::*;

  swsaa_core_t r;
  swsaa_core_t next_r;
  logic lnk_level;
  logic lnk_fall;
  logic lnk_rise;
  logic lnk_rst;
  logic lnk_long;
  logic blk;
  logic coll_set;
  logic refused;
  logic [7:0] rx_next;

  swsaa_core_if cif ();

  function automatic logic [11:0] cyc(input logic ovd, input int unsigned std_c,
                                      input int unsigned ovd_c);
    return ovd ? 12'(ovd_c - 1) : 12'(std_c - 1);
  endfunction

  function automatic logic refusable(input logic [7:0] code);
    return (code == `SWSAA_FN_CLEAR) || (code == `SWSAA_FN_FORCED) ||
           (code == `SWSAA_FN_START);
  endfunction

  swsaa_line_rx #(
    .LONG_RST_CYC(LONG_RST_CYC)
  ) u_line_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .dq_i(dq_i),
    .ovd(r.ovd),
    .self_drive(!r.dq_oe_n),
    .level(lnk_level),
    .fall(lnk_fall),
    .rise(lnk_rise),
    .rst_det(lnk_rst),
    .long_det(lnk_long)
  );

  swsaa_axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .cif(cif)
  );

  always_comb begin
    next_r = r;
    next_r.rx_valid = 1'b0;
    coll_set = 1'b0;
    rx_next = {lnk_level, r.shreg[7:1]};
    refused = refusable(rx_next) && (cif.mission || cif.alarm_wait);
    // reset and rom phases stay outside the blocking window
    blk = (r.busy_cnt != 24'h0) && (r.st == st_func || r.st == st_data);
    if (r.busy_cnt != 24'h0) begin
      next_r.busy_cnt = r.busy_cnt - 24'h1;
    end else if (cif.sample_start && (cif.mission || cif.alarm_wait)) begin
      next_r.busy_cnt = 24'(SAMPLE_CYC);
    end
    if (lnk_long) begin
      next_r.ovd = 1'b0;
    end
    if (lnk_rst) begin
      next_r.st = st_rst;
      next_r.dq_oe_n = 1'b1;
      next_r.in_slot = 1'b0;
      next_r.spoil = 1'b0;
    end else begin
      case (r.st)
        st_rst: begin
          if (lnk_rise) begin
            next_r.st = st_pwait;
            next_r.slot_cnt = 12'h0;
          end
        end
        st_pwait: begin
          next_r.slot_cnt = r.slot_cnt + 12'h1;
          if (r.slot_cnt == cyc(r.ovd, `SWSAA_CYC_PWAIT_STD, `SWSAA_CYC_PWAIT_OVD)) begin
            next_r.st = st_plow;
            next_r.slot_cnt = 12'h0;
            next_r.dq_oe_n = 1'b0;
          end
        end
        st_plow: begin
          next_r.slot_cnt = r.slot_cnt + 12'h1;
          if (r.slot_cnt == cyc(r.ovd, `SWSAA_CYC_PLOW_STD, `SWSAA_CYC_PLOW_OVD)) begin
            next_r.st = st_rom;
            next_r.dq_oe_n = 1'b1;
            next_r.bitn = 3'h0;
            next_r.in_slot = 1'b0;
          end
        end
        st_rom, st_func, st_data: begin
          if (lnk_fall && !r.in_slot) begin
            next_r.in_slot = 1'b1;
            next_r.slot_cnt = 12'h0;
            next_r.tx_slot = (r.st == st_data) && cif.tx_mode;
            if (blk) begin
              coll_set = 1'b1;
              next_r.spoil = 1'b1;
            end
            // a spoiled transfer keeps the line released so bytes read as ones
            if (next_r.tx_slot && !blk && !r.spoil && !cif.txdata[r.bitn]) begin
              next_r.dq_oe_n = 1'b0;
            end
          end else if (r.in_slot) begin
            next_r.slot_cnt = r.slot_cnt + 12'h1;
            if (r.slot_cnt == cyc(r.ovd, `SWSAA_CYC_SAMP_STD, `SWSAA_CYC_SAMP_OVD)) begin
              next_r.in_slot = 1'b0;
              next_r.dq_oe_n = 1'b1;
              if (r.tx_slot) begin
                next_r.bitn = r.bitn + 3'h1;
              end else if (!blk) begin
                next_r.shreg = rx_next;
                next_r.bitn = r.bitn + 3'h1;
                if (r.bitn == 3'h7) begin
                  if (r.st == st_rom) begin
                    next_r.rom_cmd = rx_next;
                    if (rx_next == `SWSAA_ROM_SKIP) begin
                      next_r.st = st_func;
                    end else if (rx_next == `SWSAA_ROM_OVD_SKIP) begin
                      next_r.st = st_func;
                      next_r.ovd = 1'b1;
                    end else begin
                      next_r.st = st_wait;
                    end
                  end else if (r.st == st_func) begin
                    next_r.func_cmd = rx_next;
                    if (refused) begin
                      next_r.st = st_wait;
                    end else begin
                      next_r.st = st_data;
                      if (rx_next == `SWSAA_FN_FORCED && r.busy_cnt == 24'h0) begin
                        next_r.busy_cnt = 24'(SAMPLE_CYC);
                      end
                    end
                  end else begin
                    next_r.rx_byte = rx_next;
                    next_r.rx_valid = 1'b1;
                  end
                end
              end
            end
          end
        end
        default: begin
          next_r.dq_oe_n = 1'b1;
        end
      endcase
    end
    // set wins over clear
    if (cif.coll_clr) begin
      next_r.coll = 1'b0;
    end
    if (coll_set) begin
      next_r.coll = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '{st: st_wait, dq_oe_n: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // open-drain: only ever pulls low
  assign dq_o = 1'b0;
  assign dq_oe_n = r.dq_oe_n;
  assign cif.ovd = r.ovd;
  assign cif.busy = (r.busy_cnt != 24'h0);
  assign cif.coll = r.coll;
  assign cif.phase = 3'(r.st);
  assign cif.rom_cmd = r.rom_cmd;
  assign cif.func_cmd = r.func_cmd;
  assign cif.rx_byte = r.rx_byte;
  assign cif.rx_valid = r.rx_valid;

  a_ovd_cleared: assert property (
    @(posedge aclk) disable iff (!aresetn) lnk_long |=> !r.ovd)
    else $error("overdrive flag not cleared by long reset");

  a_reset_taken: assert property (
    @(posedge aclk) disable iff (!aresetn) lnk_rst |=> (r.st == st_rst) && r.dq_oe_n)
    else $error("reset not taken");

  a_presence_low: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (r.st == st_pwait) ##1 (r.st == st_plow) |-> !r.dq_oe_n [*2])
    else $error("presence pulse not driven");

  a_drive_cause: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(r.dq_oe_n) |-> $past(lnk_fall) || $past(r.st == st_pwait))
    else $error("line driven without master slot or presence");

  a_blocked_released: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(r.dq_oe_n) && (r.st == st_data) |-> !$past(blk) && !$past(r.spoil))
    else $error("line driven while sampling blocks the bus");

  a_refuse_cmd: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ($past(r.st) == st_func) && (r.st == st_data) |->
      !(refusable(r.func_cmd) && $past(cif.mission || cif.alarm_wait)))
    else $error("refusable command accepted during mission");

  a_sample_length: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(r.busy_cnt != 24'h0) |-> r.busy_cnt == 24'(SAMPLE_CYC))
    else $error("sampling window length wrong");

  a_rom_only_skip: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ($past(r.st) == st_rom) && (r.st == st_func) |->
      (r.rom_cmd == `SWSAA_ROM_SKIP) || (r.rom_cmd == `SWSAA_ROM_OVD_SKIP))
    else $error("function phase entered without a valid rom command");

  a_coll_sticky: assert property (
    @(posedge aclk) disable iff (!aresetn)
    coll_set |=> r.coll ##1 (r.coll || $past(cif.coll_clr)))
    else $error("collision flag lost");

  a_blocked_ignore: assert property (
    @(posedge aclk) disable iff (!aresetn)
    blk && !r.tx_slot && r.in_slot |=> $stable(r.shreg))
    else $error("write slot taken while sampling blocks the bus");
endmodule
`default_nettype wire

/* File: swsaa_master_model.sv */
// behavioural single-wire bus master
`timescale 1ns/1ps
`default_nettype none
module swsaa_master_model (
  input wire logic aclk,
  input wire logic line,
  output logic pull
);
  initial pull = 1'b0;
  task automatic hold(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // reset pulse, then watch for presence
  task automatic rst(input int n, output logic pres);
    pres = 1'b0;
    pull <= 1'b1;
    hold(n);
    pull <= 1'b0;
    for (int k = 0; k < 4000; k++) begin
      @(posedge aclk);
      if (!line) pres = 1'b1;
    end
  endtask
  // one slot; od low time stays under 12us
  task automatic slot(input logic b, input logic ovd, output logic r);
    pull <= 1'b1;
    hold(ovd ? 2 : 10);
    if (b) pull <= 1'b0;
    hold(ovd ? 30 : 290);
    r = line;
    hold(ovd ? 120 : 1200);
    pull <= 1'b0;
    hold(ovd ? 60 : 300);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ovd, output logic [7:0] q);
    for (int i = 0; i < 8; i++) slot(d[i], ovd, q[i]);
  endtask
endmodule
`default_nettype wire

/* File: single_wire_slave_access_arbiter_bench.sv */
// self-checking bench for the slave front end
`timescale 1ns/1ps
`default_nettype none
`include "swsaa_defs.svh"
module single_wire_slave_access_arbiter_bench;
  logic aclk = 0, aresetn = 0, pull, dq_o, dq_oe_n, p;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, q, tx, rx;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int err_count = 0, check_count = 0, cyc = 0, seed = 32'hb340;
  wire logic line = ~pull & dq_oe_n;
  always #20 aclk = ~aclk;
  swsaa_top #(.LONG_RST_CYC(3500), .SAMPLE_CYC(2000)) uut (.aclk, .aresetn,
    .dq_i(line), .dq_o, .dq_oe_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  swsaa_master_model mst (.aclk, .line, .pull);
  function automatic logic [31:0] rx_exp(input logic [7:0] b);
    return {23'h0, 1'b1, b};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, `SWSAA_RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      conclude;
    end
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h10);
    chk(r, `SWSAA_RESP_SLVERR);
    chk(d, 32'h0);
    rd(`SWSAA_REG_TXDATA);
    chk(d, 32'hff);
    mst.rst(3200, p);
    chk(p, 1'b1);
    mst.xfer(8'h3c, 1'b0, q);
    rd(`SWSAA_REG_STATUS);
    chk(d[0], 1'b1);
    chk(d[6:4], 3'h5);
    tx = 8'($random(seed));
    wr(`SWSAA_REG_TXDATA, {24'h0, tx});
    wr(`SWSAA_REG_CTRL, 32'h4);
    mst.rst(500, p);
    chk(p, 1'b1);
    mst.xfer(8'hcc, 1'b1, q);
    mst.xfer(8'h69, 1'b1, q);
    mst.xfer(8'hff, 1'b1, q);
    chk(q, tx);
    wr(`SWSAA_REG_CTRL, 32'h0);
    rd(`SWSAA_REG_RXDATA);
    rx = 8'($random(seed));
    mst.xfer(rx, 1'b1, q);
    rd(`SWSAA_REG_RXDATA);
    chk(d, rx_exp(rx));
    wr(`SWSAA_REG_CTRL, 32'h9);
    rd(`SWSAA_REG_STATUS);
    chk(d[1], 1'b1);
    mst.xfer(8'h00, 1'b1, q);
    wr(`SWSAA_REG_TXDATA, 32'h0);
    wr(`SWSAA_REG_CTRL, 32'h5);
    mst.xfer(8'hff, 1'b1, q);
    chk(q, 8'hff);
    rd(`SWSAA_REG_RXDATA);
    chk(d[8], 1'b0);
    rd(`SWSAA_REG_STATUS);
    chk(d[2], 1'b1);
    wr(`SWSAA_REG_CTRL, 32'h2);
    mst.hold(2000);
    mst.rst(500, p);
    chk(p, 1'b1);
    mst.xfer(8'hcc, 1'b1, q);
    rd(`SWSAA_REG_STATUS);
    chk(d[15:8], 8'hcc);
    mst.xfer(8'h96, 1'b1, q);
    rd(`SWSAA_REG_STATUS);
    chk(d[6:4], 3'h0);
    wr(`SWSAA_REG_STATUS, 32'h4);
    rd(`SWSAA_REG_STATUS);
    chk(d[2], 1'b0);
    wr(`SWSAA_REG_CTRL, 32'h0);
    mst.rst(500, p);
    chk(p, 1'b1);
    mst.xfer(8'hcc, 1'b1, q);
    mst.xfer(8'h55, 1'b1, q);
    rd(`SWSAA_REG_STATUS);
    chk(d[1], 1'b1);
    chk(d[6:4], 3'h6);
    mst.rst(3600, p);
    rd(`SWSAA_REG_STATUS);
    chk(d[0], 1'b0);
    conclude;
  end
endmodule
`default_nettype wire
